/* File: src/fsq_map.vh */
`ifndef FSQ_MAP_VH
`define FSQ_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define FSQ_OFF_CTRL 5'h00
`define FSQ_OFF_ADDR 5'h04
`define FSQ_OFF_DATA 5'h08
`define FSQ_OFF_DATA2 5'h0C
`define FSQ_OFF_CMD 5'h10
`define FSQ_OFF_STATUS 5'h14
`define FSQ_OFF_RDATA 5'h18

// ****************************************
// field positions and reset values
// ****************************************
`define FSQ_CTRL_WP_BIT 0
`define FSQ_CTRL_BYPASS_BIT 1
`define FSQ_CTRL_RESET 2'h0
`define FSQ_ST_BUSY_BIT 0
`define FSQ_ST_TIMEOUT_BIT 1
`define FSQ_ST_REJECT_BIT 2

// ****************************************
// operation codes written to the command register
// ****************************************
`define FSQ_OP_NONE 4'h0
`define FSQ_OP_READ 4'h1
`define FSQ_OP_RESET 4'h2
`define FSQ_OP_PROG 4'h3
`define FSQ_OP_PAIR 4'h4
`define FSQ_OP_SECTOR 4'h5
`define FSQ_OP_QUERY 4'h6
`define FSQ_OP_BLOCK 4'h7
`define FSQ_OP_ADDBLK 4'h8
`define FSQ_OP_BANK 4'h9
`define FSQ_OP_SUSPEND 4'hA
`define FSQ_OP_RESUME 4'hB
`define FSQ_OP_POLL 4'hC

// ****************************************
// device command codes and addresses
// ****************************************
`define FSQ_ADR_UNLOCK1 21'h0_0555
`define FSQ_ADR_UNLOCK2 21'h0_02AA
`define FSQ_CODE_UNLOCK1 16'h00AA
`define FSQ_CODE_UNLOCK2 16'h0055
`define FSQ_CODE_PROG 16'h00A0
`define FSQ_CODE_PAIR 16'h0040
`define FSQ_CODE_SECTOR 16'h0060
`define FSQ_CODE_QUERY 16'h0090
`define FSQ_CODE_ERASE 16'h0080
`define FSQ_CODE_CONFIRM 16'h0030
`define FSQ_CODE_BANK 16'h0010
`define FSQ_CODE_SUSPEND 16'h00B0
`define FSQ_CODE_RESET 16'h00F0
`define FSQ_TOGGLE_BIT 6

// ****************************************
// timing
// ****************************************
`define FSQ_CLK_NS 50
`define FSQ_T_SETUP_NS 50
`define FSQ_T_PULSE_NS 100
`define FSQ_T_HOLD_NS 50
`define FSQ_T_ACCESS_NS 150
`define FSQ_SYNC_STAGES 2

`endif

/* File: src/fsq_bus_cycle.v */
`timescale 1ns/1ns
`default_nettype none

module fsq_bus_cycle #(
    parameter [7:0] SETUP_CYC = 8'h01,
    parameter [7:0] PULSE_CYC = 8'h02,
    parameter [7:0] HOLD_CYC = 8'h01,
    parameter [7:0] ACCESS_CYC = 8'h05
) (
    input wire clk, // system clock
    input wire resetn, // async reset, active low
    input wire start, // begin one cycle
    input wire isRead, // read rather than write
    input wire [20:0] addrIn, // word address
    input wire [15:0] dataIn, // write data
    input wire [15:0] dqSync, // synchronised data pins
    output reg done, // cycle finished pulse
    output reg [15:0] rdata, // sampled read word
    output reg [20:0] flashAddr, // address pins
    output reg [15:0] dqOut, // data pins driven value
    output reg dqOe, // data pins driven
    output reg csN, // flash_chip_select, low
    output reg weN, // write_strobe, low
    output reg oeN // output enable, low
);

    localparam [2:0] C_IDLE = 3'h0;
    localparam [2:0] C_SETUP = 3'h1;
    localparam [2:0] C_PULSE = 3'h2;
    localparam [2:0] C_HOLD = 3'h3;
    localparam [2:0] C_READ = 3'h4;

    reg [2:0] state_r;
    reg [7:0] cnt_r;

    // ****************************************
    // one strobed write or one read access
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= C_IDLE;
            cnt_r <= 8'h00;
            done <= 1'b0;
            rdata <= 16'h0000;
            flashAddr <= 21'h0_0000;
            dqOut <= 16'h0000;
            dqOe <= 1'b0;
            csN <= 1'b1;
            weN <= 1'b1;
            oeN <= 1'b1;
        end else begin
            done <= 1'b0;
            case (state_r)
                C_IDLE: begin
                    if (start) begin
                        flashAddr <= addrIn;
                        csN <= 1'b0;
                        if (isRead) begin
                            oeN <= 1'b0;
                            cnt_r <= ACCESS_CYC - 8'h01;
                            state_r <= C_READ;
                        end else begin
                            dqOut <= dataIn;
                            dqOe <= 1'b1;
                            cnt_r <= SETUP_CYC - 8'h01;
                            state_r <= C_SETUP;
                        end
                    end
                end
                C_SETUP: begin
                    if (cnt_r == 8'h00) begin
                        weN <= 1'b0;
                        cnt_r <= PULSE_CYC - 8'h01;
                        state_r <= C_PULSE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                C_PULSE: begin
                    // rising strobe edge latches the data word
                    if (cnt_r == 8'h00) begin
                        weN <= 1'b1;
                        cnt_r <= HOLD_CYC - 8'h01;
                        state_r <= C_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                C_HOLD: begin
                    if (cnt_r == 8'h00) begin
                        csN <= 1'b1;
                        dqOe <= 1'b0;
                        done <= 1'b1;
                        state_r <= C_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                C_READ: begin
                    if (cnt_r == 8'h00) begin
                        rdata <= dqSync;
                        oeN <= 1'b1;
                        csN <= 1'b1;
                        done <= 1'b1;
                        state_r <= C_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                default: begin
                    state_r <= C_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: src/fsq_host.v */
`timescale 1ns/1ns
`default_nettype none
`include "fsq_map.vh"

module fsq_host #(
    parameter [23:0] POLL_MAX = 24'hFF_FFFF
) (
    input wire clk, // system clock
    input wire resetn, // async reset, active low
    input wire [4:0] address, // avalon byte address
    input wire read, // avalon read
    input wire write, // avalon write
    input wire [31:0] writedata, // avalon write data
    output reg [31:0] readdata, // avalon read data
    output reg waitrequest, // avalon wait
    output wire [20:0] flashAddr, // flash address pins
    output wire [15:0] dqOut, // data pins out
    output wire dqOe, // data pins enable
    input wire [15:0] dqIn, // data pins in
    output wire flashChipSelectN, // flash_chip_select
    output wire writeStrobeN, // write_strobe
    output wire outEnN, // output enable
    output reg writeProtectPin // write_protect_pin
);

    localparam [7:0] SETUP_CYC =
        (`FSQ_T_SETUP_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS;
    localparam [7:0] PULSE_CYC =
        (`FSQ_T_PULSE_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS;
    localparam [7:0] HOLD_CYC =
        (`FSQ_T_HOLD_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS;
    localparam [7:0] ACCESS_CYC =
        (`FSQ_T_ACCESS_NS + `FSQ_CLK_NS - 1) / `FSQ_CLK_NS
        + `FSQ_SYNC_STAGES;

    localparam [1:0] K_END = 2'h0;
    localparam [1:0] K_WR = 2'h1;
    localparam [1:0] K_RD = 2'h2;
    localparam [1:0] A_555 = 2'h0;
    localparam [1:0] A_2AA = 2'h1;
    localparam [1:0] A_REG = 2'h2;
    localparam [1:0] A_PAIR = 2'h3;
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_GO = 2'h1;
    localparam [1:0] S_WAIT = 2'h2;

    reg [1:0] ctrl_r;
    reg [20:0] addr_r;
    reg [15:0] data_r;
    reg [15:0] data2_r;
    reg [3:0] op_r;
    reg [15:0] rdata_r;
    reg timeout_r;
    reg reject_r;
    reg [1:0] state_r;
    reg [2:0] step_r;
    reg [23:0] pollCnt_r;
    reg havePrev_r;
    reg prevToggle_r;
    reg [15:0] dqMeta_r;
    reg [15:0] dqSync_r;
    reg [1:0] stKind;
    reg [1:0] stSel;
    reg [15:0] stData;
    reg [15:0] setupCode;
    reg [20:0] cycAddr;
    reg [31:0] rdMux;
    wire cycDone;
    wire [15:0] cycRdata;
    wire busy = (state_r != S_IDLE);
    wire take = (read || write) && waitrequest;
    wire wrTake = write && waitrequest;
    wire cmdWr = wrTake && (address == `FSQ_OFF_CMD);
    wire usesBypass = (writedata[3:0] == `FSQ_OP_PROG) ||
        (writedata[3:0] == `FSQ_OP_PAIR);
    wire cmdOk = (writedata[3:0] != `FSQ_OP_NONE) &&
        (writedata[3:0] <= `FSQ_OP_POLL);
    wire pollEnd = havePrev_r &&
        (cycRdata[`FSQ_TOGGLE_BIT] == prevToggle_r);

    // ****************************************
    // data pin synchroniser
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dqMeta_r <= 16'h0000;
            dqSync_r <= 16'h0000;
        end else begin
            dqMeta_r <= dqIn;
            dqSync_r <= dqMeta_r;
        end
    end

    // ****************************************
    // write and read sequence table
    // ****************************************
    always @* begin
        stKind = K_END;
        stSel = A_REG;
        stData = 16'h0000;
        case (op_r)
            `FSQ_OP_PROG: setupCode = `FSQ_CODE_PROG;
            `FSQ_OP_PAIR: setupCode = `FSQ_CODE_PAIR;
            `FSQ_OP_SECTOR: setupCode = `FSQ_CODE_SECTOR;
            default: setupCode = `FSQ_CODE_QUERY;
        endcase
        case (op_r)
            `FSQ_OP_READ, `FSQ_OP_POLL: begin
                if (step_r == 3'h0) begin
                    stKind = K_RD;
                end
            end
            `FSQ_OP_RESET: begin
                if (step_r == 3'h0) begin
                    stKind = K_WR;
                    stData = `FSQ_CODE_RESET;
                end
            end
            `FSQ_OP_ADDBLK, `FSQ_OP_RESUME: begin
                if (step_r == 3'h0) begin
                    stKind = K_WR;
                    stData = `FSQ_CODE_CONFIRM;
                end
            end
            `FSQ_OP_SUSPEND: begin
                if (step_r == 3'h0) begin
                    stKind = K_WR;
                    stData = `FSQ_CODE_SUSPEND;
                end
            end
            `FSQ_OP_PROG, `FSQ_OP_PAIR, `FSQ_OP_SECTOR,
            `FSQ_OP_QUERY: begin
                case (step_r)
                    3'h0: begin
                        stKind = K_WR;
                        stSel = A_555;
                        stData = `FSQ_CODE_UNLOCK1;
                    end
                    3'h1: begin
                        stKind = K_WR;
                        stSel = A_2AA;
                        stData = `FSQ_CODE_UNLOCK2;
                    end
                    3'h2: begin
                        stKind = K_WR;
                        stSel = A_555;
                        stData = setupCode;
                    end
                    3'h3: begin
                        stKind = (op_r == `FSQ_OP_QUERY) ? K_RD : K_WR;
                        stData = data_r;
                    end
                    3'h4: begin
                        if (op_r == `FSQ_OP_PAIR) begin
                            stKind = K_WR;
                            stSel = A_PAIR;
                            stData = data2_r;
                        end
                    end
                    default: stKind = K_END;
                endcase
            end
            `FSQ_OP_BLOCK, `FSQ_OP_BANK: begin
                case (step_r)
                    3'h0, 3'h3: begin
                        stKind = K_WR;
                        stSel = A_555;
                        stData = `FSQ_CODE_UNLOCK1;
                    end
                    3'h1, 3'h4: begin
                        stKind = K_WR;
                        stSel = A_2AA;
                        stData = `FSQ_CODE_UNLOCK2;
                    end
                    3'h2: begin
                        stKind = K_WR;
                        stSel = A_555;
                        stData = `FSQ_CODE_ERASE;
                    end
                    3'h5: begin
                        stKind = K_WR;
                        stData = (op_r == `FSQ_OP_BANK) ?
                            `FSQ_CODE_BANK : `FSQ_CODE_CONFIRM;
                    end
                    default: stKind = K_END;
                endcase
            end
            default: stKind = K_END;
        endcase
        case (stSel)
            A_555: cycAddr = `FSQ_ADR_UNLOCK1;
            A_2AA: cycAddr = `FSQ_ADR_UNLOCK2;
            A_PAIR: cycAddr = {addr_r[20:1], ~addr_r[0]};
            default: cycAddr = addr_r;
        endcase
    end

    // ****************************************
    // register read mux
    // ****************************************
    always @* begin
        case (address)
            `FSQ_OFF_CTRL: rdMux = {30'h0000_0000, ctrl_r};
            `FSQ_OFF_ADDR: rdMux = {11'h000, addr_r};
            `FSQ_OFF_DATA: rdMux = {16'h0000, data_r};
            `FSQ_OFF_DATA2: rdMux = {16'h0000, data2_r};
            `FSQ_OFF_CMD: rdMux = {28'h000_0000, op_r};
            `FSQ_OFF_STATUS:
                rdMux = {29'h0000_0000, reject_r, timeout_r, busy};
            `FSQ_OFF_RDATA: rdMux = {16'h0000, rdata_r};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // avalon slave and sequencer
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
            ctrl_r <= `FSQ_CTRL_RESET;
            writeProtectPin <= 1'b0;
            addr_r <= 21'h0_0000;
            data_r <= 16'h0000;
            data2_r <= 16'h0000;
            op_r <= `FSQ_OP_NONE;
            rdata_r <= 16'h0000;
            timeout_r <= 1'b0;
            reject_r <= 1'b0;
            state_r <= S_IDLE;
            step_r <= 3'h0;
            pollCnt_r <= 24'h00_0000;
            havePrev_r <= 1'b0;
            prevToggle_r <= 1'b0;
        end else begin
            waitrequest <= ~take;
            if (take) begin
                readdata <= rdMux;
            end
            writeProtectPin <= ctrl_r[`FSQ_CTRL_WP_BIT];
            if (wrTake && !busy) begin
                case (address)
                    `FSQ_OFF_CTRL: ctrl_r <= writedata[1:0];
                    `FSQ_OFF_ADDR: addr_r <= writedata[20:0];
                    `FSQ_OFF_DATA: data_r <= writedata[15:0];
                    `FSQ_OFF_DATA2: data2_r <= writedata[15:0];
                    default: ctrl_r <= ctrl_r;
                endcase
            end
            case (state_r)
                S_IDLE: begin
                    if (cmdWr && cmdOk) begin
                        op_r <= writedata[3:0];
                        step_r <= (ctrl_r[`FSQ_CTRL_BYPASS_BIT] &&
                            usesBypass) ? 3'h2 : 3'h0;
                        timeout_r <= 1'b0;
                        reject_r <= 1'b0;
                        havePrev_r <= 1'b0;
                        pollCnt_r <= 24'h00_0000;
                        state_r <= S_GO;
                    end else if (cmdWr) begin
                        reject_r <= 1'b1;
                    end
                end
                S_GO: begin
                    state_r <= (stKind == K_END) ? S_IDLE : S_WAIT;
                end
                S_WAIT: begin
                    if (cycDone) begin
                        state_r <= S_GO;
                        if (stKind == K_RD) begin
                            rdata_r <= cycRdata;
                        end
                        if (op_r == `FSQ_OP_POLL) begin
                            // toggle bit steady means operation over
                            havePrev_r <= 1'b1;
                            prevToggle_r <= cycRdata[`FSQ_TOGGLE_BIT];
                            pollCnt_r <= pollCnt_r + 24'h00_0001;
                            if (pollEnd) begin
                                state_r <= S_IDLE;
                            end else if (pollCnt_r == POLL_MAX) begin
                                timeout_r <= 1'b1;
                                state_r <= S_IDLE;
                            end
                        end else begin
                            step_r <= step_r + 3'h1;
                        end
                    end
                end
                default: state_r <= S_IDLE;
            endcase
            if (cmdWr && busy) begin
                reject_r <= 1'b1;
            end
        end
    end

    fsq_bus_cycle #(
        .SETUP_CYC(SETUP_CYC),
        .PULSE_CYC(PULSE_CYC),
        .HOLD_CYC(HOLD_CYC),
        .ACCESS_CYC(ACCESS_CYC)
    ) fsq_bus_cycle_i (
        .clk(clk),
        .resetn(resetn),
        .start((state_r == S_GO) && (stKind != K_END)),
        .isRead(stKind == K_RD),
        .addrIn(cycAddr),
        .dataIn(stData),
        .dqSync(dqSync_r),
        .done(cycDone),
        .rdata(cycRdata),
        .flashAddr(flashAddr),
        .dqOut(dqOut),
        .dqOe(dqOe),
        .csN(flashChipSelectN),
        .weN(writeStrobeN),
        .oeN(outEnN)
    );

endmodule

`default_nettype wire

/* File: testbench/fsq_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none

module fsq_flash_model #(
    parameter logic [15:0] PROT_CODE = 16'h0001,
    parameter logic [15:0] UNPROT_CODE = 16'h00D0,
    parameter int BUSY_READS = 3
) (
    input wire logic [20:0] flashAddr, // address pins
    input wire logic [15:0] dqOut, // host data
    input wire logic flashChipSelectN, // select, low
    input wire logic writeStrobeN, // write strobe, low
    input wire logic outEnN, // output enable, low
    output wire logic [15:0] dqIn // device data
);
    logic [15:0] mem [0:15];
    logic [3:0] prot;
    logic [3:0] st;
    logic [3:0] pa;
    logic [15:0] pd;
    logic [15:0] rd;
    logic tog;
    logic qry;
    int busy;
    wire [3:0] a = flashAddr[3:0];
    wire [1:0] sec = a[3:2];
    wire [15:0] d = dqOut;

    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
        prot = 4'hF;
        st = 0;
        busy = 0;
        tog = 0;
        qry = 0;
        rd = 16'h0000;
    end

    task automatic prog(input logic [3:0] x, input logic [15:0] v);
        if (!prot[x[3:2]]) begin
            mem[x] = mem[x] & v;
            busy = BUSY_READS;
            pd = v;
        end
    endtask

    // ****************************************
    // command decoding on strobe release
    // ****************************************
    always @(posedge writeStrobeN) if (!flashChipSelectN) begin
        qry = 0;
        if (d == 16'h00F0) st = 0;
        else case (st)
            0: st = (flashAddr == 21'h555 && d == 16'h00AA) ? 1 : 0;
            1: st = (flashAddr == 21'h2AA && d == 16'h0055) ? 2 : 0;
            2: begin
                st = 0;
                if (flashAddr == 21'h555) case (d)
                    16'h00A0: st = 3;
                    16'h0040: st = 4;
                    16'h0060: st = 6;
                    16'h0080: st = 7;
                    16'h0090: qry = 1;
                    default: st = 0;
                endcase
            end
            3: begin st = 0; prog(a, d); end
            4: begin st = 5; pa = a; pd = d; end
            5: begin st = 0; prog(pa, pd); prog({pa[3:1], ~pa[0]}, d); end
            6: begin
                st = 0;
                if (d == PROT_CODE) prot[sec] = 1;
                if (d == UNPROT_CODE) prot[sec] = 0;
            end
            7: st = (flashAddr == 21'h555 && d == 16'h00AA) ? 8 : 0;
            8: st = (flashAddr == 21'h2AA && d == 16'h0055) ? 9 : 0;
            default: begin
                st = 0;
                if (d == 16'h0030 && !prot[sec]) begin
                    for (int i = 0; i < 4; i++) mem[{sec, i[1:0]}] = 16'hFFFF;
                    busy = BUSY_READS;
                    pd = 16'h00FF;
                end
            end
        endcase
    end

    // ****************************************
    // reads: status while busy, protect bit after a query, else array
    // ****************************************
    always @(negedge outEnN) if (!flashChipSelectN) begin
        #1;
        if (busy > 0) begin
            tog = ~tog;
            busy--;
            rd = {8'h00, ~pd[7], tog, 6'h00};
        end else if (qry) rd = {15'h0000, prot[sec]};
        else rd = mem[a];
    end
    // released bus shows the inverse, never a stale word
    assign dqIn = (!flashChipSelectN && !outEnN) ? rd : ~rd;
endmodule

`default_nettype wire

/* File: testbench/fsq_host_props.sv */
`timescale 1ns/1ns
`default_nettype none

module fsq_host_props #(
    parameter [23:0] POLL_MAX = 24'hFF_FFFF
) (
    input wire logic clk, // clock
    input wire logic resetn, // reset, low
    input wire logic [4:0] address, // bus address
    input wire logic read, // bus read
    input wire logic write, // bus write
    input wire logic [31:0] writedata, // bus wdata
    input wire logic [31:0] readdata, // bus rdata
    input wire logic waitrequest, // bus wait
    input wire logic [20:0] flashAddr, // pins
    input wire logic [15:0] dqOut, // pins
    input wire logic dqOe, // pins enable
    input wire logic [15:0] dqIn, // pins in
    input wire logic flashChipSelectN, // select
    input wire logic writeStrobeN, // strobe
    input wire logic outEnN, // output enable
    input wire logic writeProtectPin // protect pin
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_weLow;
        !writeStrobeN ##1 writeStrobeN;
    endsequence
    sequence s_oeLow;
        (!outEnN)[*4] ##1 outEnN;
    endsequence

    property p_wePulse;
        $fell(writeStrobeN) |=> s_weLow;
    endproperty
    a_wePulse: assert property (p_wePulse)
        else $error("write strobe width wrong");
    property p_weFrame;
        !writeStrobeN |-> !flashChipSelectN && dqOe && outEnN;
    endproperty
    a_weFrame: assert property (p_weFrame)
        else $error("strobe outside selected drive");
    property p_weHold;
        $rose(writeStrobeN) |-> !flashChipSelectN ##1 flashChipSelectN && !dqOe;
    endproperty
    a_weHold: assert property (p_weHold)
        else $error("write hold wrong");
    property p_addrStable;
        !flashChipSelectN && $past(!flashChipSelectN) |->
            $stable(flashAddr) && $stable(dqOut);
    endproperty
    a_addrStable: assert property (p_addrStable)
        else $error("address or data moved in cycle");
    property p_rdFrame;
        $fell(outEnN) |-> !flashChipSelectN && !dqOe ##1 s_oeLow;
    endproperty
    a_rdFrame: assert property (p_rdFrame)
        else $error("read cycle shape wrong");
    property p_quiet;
        flashChipSelectN |-> writeStrobeN && outEnN && !dqOe;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pins active while deselected");
    property p_waitAns;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_waitAns: assert property (p_waitAns)
        else $error("bus answer late");
    property p_waitOne;
        !waitrequest |=> waitrequest;
    endproperty
    a_waitOne: assert property (p_waitOne)
        else $error("wait low too long");
    property p_wpCause;
        $changed(writeProtectPin) |-> $past(write, 1) || $past(write, 2);
    endproperty
    a_wpCause: assert property (p_wpCause)
        else $error("protect pin moved unasked");
endmodule

bind fsq_host fsq_host_props #(.POLL_MAX(POLL_MAX)) fsq_host_props_i (
    .clk(clk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .flashAddr(flashAddr), .dqOut(dqOut),
    .dqOe(dqOe), .dqIn(dqIn), .flashChipSelectN(flashChipSelectN),
    .writeStrobeN(writeStrobeN), .outEnN(outEnN),
    .writeProtectPin(writeProtectPin)
);

`default_nettype wire

/* File: testbench/fsq_host_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fsq_map.vh"

module fsq_host_tb;
    logic clk, resetn, read, write, dqOe, csN, weN, oeN, wpPin, waitrequest;
    logic [4:0] address;
    logic [31:0] writedata, readdata, rv;
    logic [20:0] flashAddr;
    logic [15:0] dqOut, dqIn;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    fsq_host #(.POLL_MAX(24'h00_0008)) fsq_host_i (
        .clk(clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .flashAddr(flashAddr), .dqOut(dqOut),
        .dqOe(dqOe), .dqIn(dqIn), .flashChipSelectN(csN),
        .writeStrobeN(weN), .outEnN(oeN), .writeProtectPin(wpPin));
    fsq_flash_model fsq_flash_model_i (
        .flashAddr(flashAddr), .dqOut(dqOut), .flashChipSelectN(csN),
        .writeStrobeN(weN), .outEnN(oeN), .dqIn(dqIn));

    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end

    task wrap_up;
        if (miscompares == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            wrap_up;
        end
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // ****************************************
    // bus cycles
    // ****************************************
    task avw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= 1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        write <= 0;
    endtask
    task avr(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= 1;
        @(posedge clk);
        while (waitrequest) @(posedge clk);
        d = readdata;
        read <= 0;
    endtask
    task op(input logic [3:0] c);
        logic [31:0] s;
        avw(`FSQ_OFF_CMD, {28'h000_0000, c});
        s = 1;
        while (s[0]) avr(`FSQ_OFF_STATUS, s);
    endtask
    task pg(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d);
        avw(`FSQ_OFF_ADDR, {11'h000, a});
        avw(`FSQ_OFF_DATA, {16'h0000, d});
        op(c);
    endtask
    task rdw(input logic [20:0] a);
        avw(`FSQ_OFF_ADDR, {11'h000, a});
        op(`FSQ_OP_READ);
        avr(`FSQ_OFF_RDATA, rv);
    endtask
    task qry(input logic [20:0] a);
        avw(`FSQ_OFF_ADDR, {11'h000, a});
        op(`FSQ_OP_QUERY);
        avr(`FSQ_OFF_RDATA, rv);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        resetn = 0;
        read = 0;
        write = 0;
        address = 5'h00;
        writedata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        resetn <= 1;
        avr(`FSQ_OFF_CTRL, rv);
        chk(rv, 32'h0000_0000);
        avr(`FSQ_OFF_STATUS, rv);
        chk(rv, 32'h0000_0000);
        avr(5'h1C, rv);
        chk(rv, 32'h0000_0000);
        pg(`FSQ_OP_PROG, 21'h0_0005, 16'h1234);
        op(`FSQ_OP_POLL);
        rdw(21'h0_0005);
        chk(rv, 32'h0000_FFFF);
        qry(21'h0_0005);
        chk(rv, 32'h0000_0001);
        pg(`FSQ_OP_SECTOR, 21'h0_0005, 16'h00D0);
        pg(`FSQ_OP_PROG, 21'h0_0005, 16'h1234);
        op(`FSQ_OP_POLL);
        rdw(21'h0_0005);
        chk(rv, 32'h0000_1234);
        pg(`FSQ_OP_PROG, 21'h0_0005, 16'hFF00);
        op(`FSQ_OP_READ);
        avr(`FSQ_OFF_RDATA, rv);
        chk(rv & 32'h0000_0080, 32'h0000_0080);
        op(`FSQ_OP_POLL);
        rdw(21'h0_0005);
        chk(rv, 32'h0000_1200);
        pg(`FSQ_OP_BLOCK, 21'h0_0005, 16'h0000);
        op(`FSQ_OP_READ);
        avr(`FSQ_OFF_RDATA, rv);
        chk(rv & 32'h0000_0080, 32'h0000_0000);
        op(`FSQ_OP_POLL);
        rdw(21'h0_0005);
        chk(rv, 32'h0000_FFFF);
        avw(`FSQ_OFF_DATA2, 32'h0000_5555);
        pg(`FSQ_OP_PAIR, 21'h0_0004, 16'hAAAA);
        op(`FSQ_OP_POLL);
        rdw(21'h0_0004);
        chk(rv, 32'h0000_AAAA);
        rdw(21'h0_0005);
        chk(rv, 32'h0000_5555);
        pg(`FSQ_OP_SECTOR, 21'h0_0005, 16'h0001);
        qry(21'h0_0005);
        chk(rv, 32'h0000_0001);
        avw(`FSQ_OFF_CMD, 32'h0000_000D);
        avr(`FSQ_OFF_STATUS, rv);
        chk(rv, 32'h0000_0004);
        avw(`FSQ_OFF_CTRL, 32'h0000_0001);
        avr(`FSQ_OFF_CTRL, rv);
        chk(rv, 32'h0000_0001);
        chk({31'h0000_0000, wpPin}, 32'h0000_0001);
        wrap_up;
    end
endmodule

`default_nettype wire
